// >>> hw/scb_map.svh
// Field positions, port select bit, reset values and sizes of the snoop unit
`ifndef SCB_MAP_SVH
`define SCB_MAP_SVH
// Memory attribute vector bit positions
`define SCB_ATTR_WB       0
`define SCB_ATTR_SH       1
`define SCB_ATTR_NORM     2
`define SCB_ATTR_W        3
// Configuration defaults and limits
`define SCB_NCORES_DEF    4
`define SCB_NCORES_MAX    4
`define SCB_NMP_DEF       1
`define SCB_NMP_MAX       2
`define SCB_NSPI_DEF      224
`define SCB_NSPI_MAX      224
`define SCB_AW_DEF        32
`define SCB_OP_W          4
// Address bit that splits traffic between two master ports
`define SCB_PORT_SEL_BIT  12
// Reset levels
`define SCB_RST_IRQ_N     1'b1
`endif

// >>> hw/scb_pkg.sv
// Types and decode helpers shared by the snoop unit modules
package scb_pkg;
    timeunit 1ns;
    timeprecision 1ps;
`include "scb_map.svh"

    typedef enum logic [4:0] {
        SCB_IDLE  = 5'h01,
        SCB_SNOOP = 5'h02,
        SCB_ISSUE = 5'h04,
        SCB_BCAST = 5'h08,
        SCB_DONE  = 5'h10
    } scb_state_t;

    typedef logic [`SCB_ATTR_W-1:0] scb_attr_t;

    // Write-back, shareable, normal: hardware keeps it coherent
    function automatic logic scb_coherent(input scb_attr_t a);
        return a[`SCB_ATTR_WB] & a[`SCB_ATTR_SH] & a[`SCB_ATTR_NORM];
    endfunction

    // Only write-back normal memory may be cached
    function automatic logic scb_cacheable(input scb_attr_t a);
        return a[`SCB_ATTR_WB] & a[`SCB_ATTR_NORM];
    endfunction
endpackage

// >>> hw/scb_arb_if.sv
// Request and grant carrier between control logic and arbiter
interface scb_arb_if #(parameter int N = 9);
    timeunit 1ns;
    timeprecision 1ps;
    logic [N-1:0] req;
    logic [N-1:0] gnt;
    logic         take;
    modport ctl (output req, output take, input gnt);
    modport arb (input req, input take, output gnt);
endinterface

// >>> hw/scb_rr_arb.sv
// Round-robin arbiter with one-hot grant
module scb_rr_arb
    import scb_pkg::*;
#(
    parameter int N = 9
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Requests and grant
    scb_arb_if.arb   arb
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int IW = (N > 1) ? $clog2(N) : 1;

    typedef struct packed {
        logic [IW-1:0] last;
    } scb_arb_st_t;

    scb_arb_st_t st;
    scb_arb_st_t next_st;
    int          idx;
    logic        found;

    // Search starts one past the last winner
    always_comb begin
        next_st = st;
        arb.gnt = '0;
        found   = 1'b0;
        idx     = 0;
        for (int k = 1; k <= N; k++) begin
            idx = (int'(st.last) + k) % N;
            if (!found && arb.req[idx]) begin
                found        = 1'b1;
                arb.gnt[idx] = 1'b1;
                if (arb.take) begin
                    next_st.last = IW'(idx);
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= '{last: IW'(N - 1)};
        end else begin
            st <= next_st;
        end
    end
endmodule // scb_rr_arb

// >>> hw/scb_snoop_control_unit.sv
// Snoop control unit: coherency, arbitration, maintenance broadcast
// Notes on behaviour
// R1: Data caches are kept coherent only among cores in coherent mode.
// R2: Only write-back shareable normal memory gets hardware coherency.
// R3: Shareable memory that is not write-back normal goes out uncached.
// R4: A core broadcasts maintenance only with coherent mode and enable set.
// R5: Only cores in coherent mode receive and execute broadcast operations.
// R6: One to four cores attach, set by a parameter.
// R7: The unit arbitrates core requests and issues them on master ports.
// R8: Instruction fetches are never snooped.
// R9: Ordering is weak; no ordering is forced across requesters or ports.
// R10: One or two master ports and one coherent slave port are offered.
// R11: Shared interrupt inputs, up to 224, feed the interrupt controller.
// R12: Every core has its own low-active normal and fast interrupt inputs.
// R13: A broadcast completes only after all eligible receivers executed it.
// R14: Coherent-port requests are snooped against coherent cores first.
`include "scb_map.svh"
module scb_snoop_control_unit
    import scb_pkg::*;
#(
    parameter int NC   = `SCB_NCORES_DEF,
    parameter int NMP  = `SCB_NMP_DEF,
    parameter int NSPI = `SCB_NSPI_DEF,
    parameter int AW   = `SCB_AW_DEF
) (
    // Clock and reset
    input  wire logic                          i_clk,
    input  wire logic                          i_arst_n,
    // Per-core mode control
    input  wire logic [NC-1:0]                 i_coherent_mode_bit,
    input  wire logic [NC-1:0]                 i_maintenance_broadcast_enable,
    // Core data requests, held until acknowledged
    input  wire logic [NC-1:0]                 i_req_valid,
    input  wire logic [NC-1:0][AW-1:0]         i_req_addr,
    input  wire logic [NC-1:0]                 i_req_write,
    input  wire logic [NC-1:0]                 i_req_ifetch,
    input  wire scb_attr_t [NC-1:0]            i_req_attr,
    output logic      [NC-1:0]                 o_req_ack,
    // Core maintenance requests, held until acknowledged
    input  wire logic [NC-1:0]                 i_maint_req,
    input  wire logic [NC-1:0][`SCB_OP_W-1:0]  i_maint_op,
    output logic      [NC-1:0]                 o_maint_ack,
    // Broadcast maintenance toward receiving cores
    output logic      [NC-1:0]                 o_maint_valid,
    output logic      [`SCB_OP_W-1:0]          o_maint_op,
    input  wire logic [NC-1:0]                 i_maint_done,
    // Snoops toward core data caches
    output logic      [NC-1:0]                 o_snoop_valid,
    output logic      [AW-1:0]                 o_snoop_addr,
    output logic                               o_snoop_write,
    input  wire logic [NC-1:0]                 i_snoop_done,
    // Accelerator coherent slave port
    input  wire logic                          i_coh_slave_valid,
    input  wire logic [AW-1:0]                 i_coh_slave_addr,
    input  wire logic                          i_coh_slave_write,
    input  wire scb_attr_t                     i_coh_slave_attr,
    output logic                               o_coh_slave_ack,
    // Master ports toward level-two memory
    output logic      [NMP-1:0]                o_m_valid,
    output logic      [AW-1:0]                 o_m_addr,
    output logic                               o_m_write,
    output logic                               o_m_cacheable,
    output logic      [$clog2(2*NC+1)-1:0]     o_m_src,
    input  wire logic [NMP-1:0]                i_m_ready,
    // Interrupt pins in and synchronised copies out
    input  wire logic [NSPI-1:0]               i_shared_irq,
    input  wire logic [NC-1:0]                 i_normal_interrupt_request_low,
    input  wire logic [NC-1:0]                 i_fast_interrupt_request_low,
    output logic      [NSPI-1:0]               o_shared_irq,
    output logic      [NC-1:0]                 o_normal_interrupt_request_low,
    output logic      [NC-1:0]                 o_fast_interrupt_request_low
);
    timeunit 1ns;
    timeprecision 1ps;
    // R6: core count limited to one to four
    localparam int NCC = (NC < 1) ? 1 :
                         (NC > `SCB_NCORES_MAX) ? `SCB_NCORES_MAX : NC;
    // R10: one or two master ports
    localparam int NMPC = (NMP > 1) ? `SCB_NMP_MAX : 1;
    localparam int NR   = 2 * NC + 1;
    localparam int SW   = $clog2(NR);
    localparam int PW   = (NMP > 1) ? 1 : 1;

    typedef struct packed {
        scb_state_t            state;
        logic [NR-1:0]         gnt;
        logic [AW-1:0]         addr;
        logic                  write;
        logic                  cach;
        logic [PW-1:0]         port;
        logic [SW-1:0]         src;
        logic [`SCB_OP_W-1:0]  op;
        logic [NC-1:0]         snoop_v;
        logic [NC-1:0]         maint_v;
        logic [NMP-1:0]        m_valid;
        logic [NC-1:0]         req_ack;
        logic [NC-1:0]         maint_ack;
        logic                  slv_ack;
        logic [NSPI-1:0]       spi_s1;
        logic [NSPI-1:0]       spi_s2;
        logic [NC-1:0]         irq_s1;
        logic [NC-1:0]         irq_s2;
        logic [NC-1:0]         fiq_s1;
        logic [NC-1:0]         fiq_s2;
    } scb_st_t;

    scb_st_t          st;
    scb_st_t          next_st;
    scb_arb_if #(.N(NR)) arb_bus();

    logic [NC-1:0]    self;
    logic [NC-1:0]    peers;
    scb_attr_t        attr;
    logic             ifetch;
    logic             coh;

    // R7: requests enter arbitration only while idle
    assign arb_bus.req  = (st.state == SCB_IDLE) ?
                          {i_coh_slave_valid, i_maint_req, i_req_valid} : '0;
    assign arb_bus.take = (st.state == SCB_IDLE) && (|arb_bus.req);

    scb_rr_arb #(.N(NR)) u_arb (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .arb      (arb_bus)
    );

    always_comb begin
        next_st           = st;
        next_st.req_ack   = '0;
        next_st.maint_ack = '0;
        next_st.slv_ack   = 1'b0;
        self              = '0;
        peers             = '0;
        attr              = i_coh_slave_attr;
        ifetch            = 1'b0;
        coh               = 1'b0;
        // R11: shared interrupt lines through two flops
        next_st.spi_s1 = i_shared_irq;
        next_st.spi_s2 = st.spi_s1;
        // R12: per-core low-active interrupt lines
        next_st.irq_s1 = i_normal_interrupt_request_low;
        next_st.irq_s2 = st.irq_s1;
        next_st.fiq_s1 = i_fast_interrupt_request_low;
        next_st.fiq_s2 = st.fiq_s1;

        case (st.state)
            SCB_IDLE: begin
                if (arb_bus.take) begin
                    next_st.gnt   = arb_bus.gnt;
                    next_st.addr  = i_coh_slave_addr;
                    next_st.write = i_coh_slave_write;
                    next_st.src   = SW'(2 * NC);
                    for (int i = 0; i < NCC; i++) begin
                        if (arb_bus.gnt[i]) begin
                            self[i]       = 1'b1;
                            attr          = i_req_attr[i];
                            ifetch        = i_req_ifetch[i];
                            next_st.addr  = i_req_addr[i];
                            next_st.write = i_req_write[i];
                            next_st.src   = SW'(i);
                        end
                        if (arb_bus.gnt[NC+i]) begin
                            self[i]    = 1'b1;
                            next_st.op = i_maint_op[i];
                            next_st.src = SW'(NC + i);
                        end
                    end
                    // R5: receivers are the other coherent-mode cores
                    peers = i_coherent_mode_bit & ~self;
                    if (|arb_bus.gnt[2*NC-1:NC]) begin
                        // R4: broadcast needs both control bits of issuer
                        if ((|(self & i_coherent_mode_bit &
                               i_maintenance_broadcast_enable)) &&
                            (|peers)) begin
                            next_st.maint_v = peers;
                            next_st.state   = SCB_BCAST;
                        end else begin
                            next_st.maint_ack = self;
                            next_st.state     = SCB_DONE;
                        end
                    end else begin
                        // R2: coherency only for write-back shareable normal
                        // R8: instruction fetches bypass snooping
                        // R1: issuing core must itself be coherent
                        // R14: coherent-port requests snoop all coherent cores
                        coh = scb_coherent(attr) && !ifetch &&
                              (arb_bus.gnt[2*NC] ||
                               (|(self & i_coherent_mode_bit)));
                        // R3: shareable non-write-back data goes uncached
                        next_st.cach = scb_cacheable(attr);
                        next_st.port = (NMPC > 1) ?
                            PW'(next_st.addr[`SCB_PORT_SEL_BIT]) : '0;
                        if (coh && (|peers)) begin
                            next_st.snoop_v = peers;
                            next_st.state   = SCB_SNOOP;
                        end else begin
                            next_st.m_valid[next_st.port] = 1'b1;
                            next_st.state                 = SCB_ISSUE;
                        end
                    end
                end
            end
            SCB_SNOOP: begin
                next_st.snoop_v = st.snoop_v & ~i_snoop_done;
                if (next_st.snoop_v == '0) begin
                    next_st.m_valid[st.port] = 1'b1;
                    next_st.state            = SCB_ISSUE;
                end
            end
            SCB_ISSUE: begin
                // R9: each port is waited on alone, no cross-port barrier
                if (i_m_ready[st.port]) begin
                    next_st.m_valid = '0;
                    next_st.req_ack = st.gnt[NC-1:0];
                    next_st.slv_ack = st.gnt[2*NC];
                    next_st.state   = SCB_DONE;
                end
            end
            SCB_BCAST: begin
                // R13: issuer acknowledged after every receiver is done
                next_st.maint_v = st.maint_v & ~i_maint_done;
                if (next_st.maint_v == '0) begin
                    next_st.maint_ack = st.gnt[2*NC-1:NC];
                    next_st.state     = SCB_DONE;
                end
            end
            SCB_DONE: begin
                // Gives the requester a cycle to drop its request
                next_st.state = SCB_IDLE;
            end
            default: begin
                next_st.state = SCB_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= '{state:  SCB_IDLE,
                    irq_s1: {NC{`SCB_RST_IRQ_N}},
                    irq_s2: {NC{`SCB_RST_IRQ_N}},
                    fiq_s1: {NC{`SCB_RST_IRQ_N}},
                    fiq_s2: {NC{`SCB_RST_IRQ_N}},
                    default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign o_req_ack                      = st.req_ack;
    assign o_maint_ack                    = st.maint_ack;
    assign o_maint_valid                  = st.maint_v;
    assign o_maint_op                     = st.op;
    assign o_snoop_valid                  = st.snoop_v;
    assign o_snoop_addr                   = st.addr;
    assign o_snoop_write                  = st.write;
    assign o_coh_slave_ack                = st.slv_ack;
    assign o_m_valid                      = st.m_valid;
    assign o_m_addr                       = st.addr;
    assign o_m_write                      = st.write;
    assign o_m_cacheable                  = st.cach;
    assign o_m_src                        = st.src;
    assign o_shared_irq                   = st.spi_s2;
    assign o_normal_interrupt_request_low = st.irq_s2;
    assign o_fast_interrupt_request_low   = st.fiq_s2;
endmodule // scb_snoop_control_unit

// >>> test/scb_far_model.sv
// Cores and level-two memory answering the snoop unit
module scb_far_model #(
    parameter int NC  = 2,
    parameter int NMP = 1
) (
    // Clock, reset and answer speed
    input  wire logic           i_clk,
    input  wire logic           i_arst_n,
    input  wire logic           i_slow,
    // Requests from the unit
    input  wire logic [NC-1:0]  i_snoop_valid,
    input  wire logic [NC-1:0]  i_maint_valid,
    input  wire logic [NMP-1:0] i_m_valid,
    // Answers to the unit
    output logic      [NC-1:0]  o_snoop_done,
    output logic      [NMP-1:0] o_m_ready,
    output logic      [NC-1:0]  o_maint_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_cnt;
    logic       busy;
    logic       go;
    assign busy = |{i_snoop_valid, i_maint_valid, i_m_valid};
    assign go   = !i_slow || wait_cnt == 2'h3;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) wait_cnt <= 2'h0;
        else if (busy && !go) wait_cnt <= wait_cnt + 2'h1;
        else wait_cnt <= 2'h0;
    end
    assign o_maint_done = go ? i_maint_valid : '0;
    assign o_snoop_done = go ? i_snoop_valid : '0;
    assign o_m_ready    = go ? i_m_valid : '0;
endmodule // scb_far_model

// >>> test/scb_snoop_control_unit_sva.sv
// Checker on the snoop unit ports
module scb_snoop_control_unit_sva
    import scb_pkg::*;
#(
    parameter int NC   = 2,
    parameter int NMP  = 1,
    parameter int NSPI = 32,
    parameter int AW   = 32
) (
    input wire logic                      i_clk,
    input wire logic                      i_arst_n,
    input wire logic [NC-1:0]             i_coherent_mode_bit,
    input wire logic [NC-1:0]             i_maintenance_broadcast_enable,
    input wire scb_attr_t [NC-1:0]        i_req_attr,
    input wire logic [NC-1:0]             o_req_ack,
    input wire logic [NC-1:0]             o_maint_ack,
    input wire logic [NC-1:0]             o_maint_valid,
    input wire logic [NC-1:0]             i_maint_done,
    input wire logic [NC-1:0]             o_snoop_valid,
    input wire logic [NMP-1:0]            o_m_valid,
    input wire logic                      o_m_cacheable,
    input wire logic [$clog2(2*NC+1)-1:0] o_m_src,
    input wire logic [NMP-1:0]            i_m_ready,
    input wire logic [NC-1:0]             i_normal_interrupt_request_low,
    input wire logic [NC-1:0]             o_normal_interrupt_request_low,
    input wire logic [NSPI-1:0]           i_shared_irq,
    input wire logic [NSPI-1:0]           o_shared_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    a_snoop_coherent_only: assert property (
        (o_snoop_valid & ~i_coherent_mode_bit) == '0)
        else $error("snoop to core out of coherent mode");
    a_recv_coherent_only: assert property (
        (o_maint_valid & ~i_coherent_mode_bit) == '0)
        else $error("broadcast to core out of coherent mode");
    a_bcast_needs_bits: assert property (
        $rose(o_maint_valid[1]) |->
            $past(i_coherent_mode_bit[0]) &&
            $past(i_maintenance_broadcast_enable[0]))
        else $error("broadcast without both control bits");
    a_maint_ack_last: assert property (
        o_maint_ack != '0 |->
            ($past(o_maint_valid) & ~$past(i_maint_done)) == '0)
        else $error("maintenance acked before receivers finished");
    a_ack_single_pulse: assert property (
        o_req_ack[0] |=> !o_req_ack[0])
        else $error("data ack longer than one cycle");
    a_ack_after_ready: assert property (
        o_req_ack[0] |-> $past(o_m_valid[0]) && $past(i_m_ready[0]))
        else $error("ack without memory accept");
    a_master_hold: assert property (
        o_m_valid[0] && !i_m_ready[0] |=>
            o_m_valid[0] && $stable(o_m_src))
        else $error("master request dropped");
    a_cacheable_attr: assert property (
        o_m_valid[0] && o_m_src < NC |->
            o_m_cacheable == (i_req_attr[o_m_src][0] &
                              i_req_attr[o_m_src][2]))
        else $error("cacheable flag disagrees with attributes");
    a_irq_two_flops: assert property (
        o_normal_interrupt_request_low ==
            $past(i_normal_interrupt_request_low, 2))
        else $error("irq copy wrong");
    a_spi_two_flops: assert property (
        o_shared_irq == $past(i_shared_irq, 2))
        else $error("shared irq copy wrong");
endmodule // scb_snoop_control_unit_sva

// >>> test/scb_snoop_control_unit_tb.sv
// Self-checking bench for the snoop unit
module scb_snoop_control_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import scb_pkg::*;
    localparam int NC = 2, NMP = 1, NSPI = 32, AW = 32;
    typedef struct packed {
        logic [1:0] mode;
        logic       ifetch;
        scb_attr_t  attr;
        logic       snp;
        logic       cach;
    } scb_row_t;
    logic clk = 0, rst_n = 0, slow = 0, av = 0, awr = 0, aack, swr, mw, mc;
    logic [NC-1:0] mode = '0, bcen = '0, rv = '0, rw = '0, rif = '0;
    logic [NC-1:0] mreq = '0, rack, mack, mval, mdone, sval, sdone;
    logic [NC-1:0] nrm_low = '1, firq = '1, onirq, ofirq;
    logic [NC-1:0][AW-1:0] raddr = '0;
    logic [NC-1:0][3:0] mop = '0;
    scb_attr_t [NC-1:0] rattr = '0;
    scb_attr_t aattr = '0;
    logic [3:0] mop_o;
    logic [AW-1:0] saddr, maddr, aaddr = '0;
    logic [NMP-1:0] mv, mrdy;
    logic [2:0] msrc;
    logic [NSPI-1:0] spi = '0, ospi;
    logic [1:0] s, m, got;
    logic [3:0] o;
    logic c;
    logic [7:0] srcs;
    logic [7:0] ma, sa;
    logic wr, sw;
    int mismatches = 0, n_compared = 0;
    scb_row_t rows[7] = '{{2'h3, 1'h0, 3'h7, 1'h1, 1'h1}, {2'h1, 1'h0, 3'h7, 1'h0, 1'h1},
        {2'h3, 1'h0, 3'h3, 1'h0, 1'h0}, {2'h3, 1'h0, 3'h6, 1'h0, 1'h0},
        {2'h3, 1'h0, 3'h5, 1'h0, 1'h1}, {2'h3, 1'h1, 3'h7, 1'h0, 1'h1},
        {2'h2, 1'h0, 3'h7, 1'h0, 1'h1}};
    always #2.5 clk = ~clk;
    scb_snoop_control_unit #(
        .NC(NC), .NMP(NMP), .NSPI(NSPI), .AW(AW)
    ) scb_snoop_control_unit_i (
        .i_clk(clk), .i_arst_n(rst_n), .i_coherent_mode_bit(mode),
        .i_maintenance_broadcast_enable(bcen), .i_req_valid(rv),
        .i_req_addr(raddr), .i_req_write(rw), .i_req_ifetch(rif),
        .i_req_attr(rattr), .o_req_ack(rack), .i_maint_req(mreq),
        .i_maint_op(mop), .o_maint_ack(mack), .o_maint_valid(mval),
        .o_maint_op(mop_o), .i_maint_done(mdone), .o_snoop_valid(sval),
        .o_snoop_addr(saddr), .o_snoop_write(swr), .i_snoop_done(sdone),
        .i_coh_slave_valid(av), .i_coh_slave_addr(aaddr),
        .i_coh_slave_write(awr), .i_coh_slave_attr(aattr),
        .o_coh_slave_ack(aack), .o_m_valid(mv), .o_m_addr(maddr),
        .o_m_write(mw), .o_m_cacheable(mc), .o_m_src(msrc),
        .i_m_ready(mrdy), .i_shared_irq(spi),
        .i_normal_interrupt_request_low(nrm_low),
        .i_fast_interrupt_request_low(firq), .o_shared_irq(ospi),
        .o_normal_interrupt_request_low(onirq),
        .o_fast_interrupt_request_low(ofirq));
    scb_far_model #(.NC(NC), .NMP(NMP)) scb_far_model_i (
        .i_clk(clk), .i_arst_n(rst_n), .i_slow(slow), .i_snoop_valid(sval),
        .i_maint_valid(mval), .i_m_valid(mv), .o_snoop_done(sdone), .o_m_ready(mrdy),
        .o_maint_done(mdone));
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Kind 0 core 0 data, 1 coherent port, 2 core 0 maintenance
    task automatic xfer(input int kind);
        int n;
        logic ack;
        s = '0; m = '0; o = '0; c = 1'b0; n = 0;
        ma = 8'hff; sa = 8'hff; wr = 1'bx; sw = 1'bx;
        if (kind == 0) rv[0] = 1'b1;
        else if (kind == 1) av = 1'b1;
        else mreq[0] = 1'b1;
        do begin
            @(posedge clk) #1;
            s |= sval;
            m |= mval;
            if (mval != '0) o = mop_o;
            if (mv[0]) begin
                c  = mc;
                ma = maddr[19:12];
                wr = mw;
            end
            if (sval != '0) begin
                sa = saddr[19:12];
                sw = swr;
            end
            ack = kind == 0 ? rack[0] : kind == 1 ? aack : mack[0];
            n++;
        end while (ack !== 1'b1 && n < 60);
        check("ack", ack, 8'h1);
        rv[0] = 1'b0; av = 1'b0; mreq[0] = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    initial begin
        #50us;
        mismatches++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge clk);
        #1;
        check("reset acks", {rack, mack, sval, mv}, 8'h0);
        check("reset irq", onirq, 8'h3);
        rst_n = 1'b1;
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 7; i++) begin
                slow = p[0]; mode = rows[i].mode; rif[0] = rows[i].ifetch;
                rattr[0] = rows[i].attr; raddr[0] = 32'h0000_1000 * i;
                rw[0] = i[0];
                xfer(0);
                check("snooped", |s, rows[i].snp);
                check("cacheable", c, rows[i].cach);
                check("master addr", ma, 8'(i));
                check("master write", wr, i[0]);
            end
        end
        rif[0] = 1'b0; mode = 2'h3; aattr = 3'h7;
        awr = 1'b1; aaddr = 32'h0000_5000;
        xfer(1);
        check("slave snoop all", s, 8'h3);
        check("slave snoop addr", sa, 8'h5);
        check("slave snoop write", sw, 8'h1);
        check("slave master addr", ma, 8'h5);
        mode = 2'h1;
        xfer(1);
        check("slave snoop coherent", s, 8'h1);
        mode = 2'h3; aattr = 3'h3;
        xfer(1);
        check("slave plain", s, 8'h0);
        for (int j = 0; j < 3; j++) begin
            mode = j == 2 ? 2'h1 : 2'h3; bcen = j == 1 ? 2'h0 : 2'h1;
            mop[0] = 4'h9 + j[3:0];
            xfer(2);
            check("broadcast targets", m, j == 0 ? 8'h2 : 8'h0);
            if (j == 0) check("broadcast op", o, 8'h9);
        end
        slow = 1'b0; mode = 2'h0; rattr = '0; rv = 2'h3; got = '0; srcs = '0;
        for (int k = 0; k < 60 && got != 2'h3; k++) begin
            @(posedge clk) #1;
            got |= rack;
            rv &= ~rack;
            if (mv[0]) srcs[msrc] = 1'b1;
        end
        check("both served", got, 8'h3);
        check("both sources", srcs, 8'h3);
        nrm_low = 2'h2; firq = 2'h1; spi = 32'h8000_0001;
        repeat (2) @(posedge clk);
        #1;
        check("normal irq", onirq, 8'h2);
        check("fast irq", ofirq, 8'h1);
        check("shared irq", {ospi[31], ospi[6:0]}, 8'h81);
        conclude();
    end
endmodule // scb_snoop_control_unit_tb
bind scb_snoop_control_unit scb_snoop_control_unit_sva #(.NC(NC), .NMP(NMP), .NSPI(NSPI), .AW(AW))
    scb_chk_i (.*);
